/* File: core/sbl_acc_if.sv */
// request/answer pair between the list sequencer and the access engine
// assumes one access outstanding at a time, start only while the engine is idle
interface sbl_acc_if;
	import sbl_pkg::*;
	logic start;
	sbl_acc_type op;
	logic [15:0] addr;
	logic [15:0] wdata;
	logic [15:0] mask;
	logic done;
	logic [15:0] rdata;
	modport ctl (output start, output op, output addr, output wdata, output mask,
		input done, input rdata);
	modport eng (input start, input op, input addr, input wdata, input mask,
		output done, output rdata);
endinterface : sbl_acc_if

/* File: core/sbl_access.sv */
// access engine: plain write, read, or read-modify-write on the core register space
// assumes cfg_ack is a one-cycle answer given while cfg_req is high
module sbl_access
	import sbl_pkg::*;
(
	input wire logic clk,
	input wire logic rst_q_n,
	sbl_acc_if.eng acc,
	output logic cfg_req,
	output logic cfg_we,
	output logic [15:0] cfg_addr,
	output logic [15:0] cfg_wdata,
	input wire logic cfg_ack,
	input wire logic [15:0] cfg_rdata
);
	typedef enum logic [1:0] {E_IDLE, E_RD, E_GAP, E_WR} sbl_eng_type;
	typedef struct packed {
		sbl_eng_type st;
		sbl_acc_type op;
		logic req;
		logic we;
		logic [15:0] addr;
		logic [15:0] wdata;
		logic [15:0] mask;
		logic [15:0] rdata;
		logic done;
	} sbl_eng_state_type;
	sbl_eng_state_type s_ff, nxt_s;

	always_comb begin
		nxt_s = s_ff;
		nxt_s.done = 1'b0;
		case (s_ff.st)
			E_IDLE: begin
				if (acc.start) begin
					nxt_s.op = acc.op;
					nxt_s.addr = acc.addr;
					nxt_s.wdata = acc.wdata;
					nxt_s.mask = acc.mask;
					nxt_s.req = 1'b1;
					nxt_s.we = (acc.op == ACC_WR);
					nxt_s.st = (acc.op == ACC_WR) ? E_WR : E_RD;
				end
			end
			E_RD: begin
				if (cfg_ack) begin
					nxt_s.req = 1'b0;
					nxt_s.rdata = cfg_rdata;
					// field writes keep the bits outside the mask as the core holds them
					nxt_s.wdata = (cfg_rdata & ~s_ff.mask) | (s_ff.wdata & s_ff.mask);
					if (s_ff.op == ACC_RMW) begin
						nxt_s.st = E_GAP;
					end else begin
						nxt_s.done = 1'b1;
						nxt_s.st = E_IDLE;
					end
				end
			end
			E_GAP: begin
				nxt_s.req = 1'b1;
				nxt_s.we = 1'b1;
				nxt_s.st = E_WR;
			end
			E_WR: begin
				if (cfg_ack) begin
					nxt_s.req = 1'b0;
					nxt_s.we = 1'b0;
					nxt_s.done = 1'b1;
					nxt_s.st = E_IDLE;
				end
			end
			default: begin
				nxt_s.st = E_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_q_n) begin
		if (!rst_q_n) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign cfg_req = s_ff.req;
	assign cfg_we = s_ff.we;
	assign cfg_addr = s_ff.addr;
	assign cfg_wdata = s_ff.wdata;
	assign acc.done = s_ff.done;
	assign acc.rdata = s_ff.rdata;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_q_n);

	sequence s_rmw_read_ack;
		cfg_req && !cfg_we && cfg_ack && s_ff.op == ACC_RMW;
	endsequence
	sequence s_rmw_write;
		!cfg_req ##1 (cfg_req && cfg_we && $stable(cfg_addr));
	endsequence
	property p_req_held;
		cfg_req && !cfg_ack |=> cfg_req && $stable(cfg_addr) && $stable(cfg_we);
	endproperty
	a_req_held: assert property (p_req_held) else $error("request dropped before ack"); // R25
	property p_rmw_order;
		s_rmw_read_ack |=> s_rmw_write;
	endproperty
	a_rmw_order: assert property (p_rmw_order) else $error("field write not after read"); // R25
	property p_rmw_merge;
		// read data is only valid in the ack cycle, so it is taken one cycle back
		s_rmw_read_ack |=> cfg_wdata == (($past(cfg_rdata) & ~s_ff.mask)
			| ($past(s_ff.wdata) & s_ff.mask));
	endproperty
	a_rmw_merge: assert property (p_rmw_merge) else $error("field merge wrong"); // R6
endmodule : sbl_access

/* File: core/sbl_loader.sv */
// self-start managed-switch boot configuration loader, top level
// assumes straps are stable at reset release and the core answers every access
// Operation
// R1 - run managed list when mode strap upper bit set
// R2 - mode 11: program slave management address field
// R3 - mode 10: SPI edges are inverted edge straps
// R4 - mode 10: SPI enable, pin alternate selects
// R5 - enable RGMII port5, force its link
// R6 - submode bit4: port5 receive delay 2 ns
// R7 - submode bit3: port5 transmit delay 2 ns
// R8 - force port4 link control value
// R9 - submode bit2: select 2.5 Gbps serial
// R10 - release serial logic from reset
// R11 - start hardware bring-up machine
// R12 - poll status until bits 11:7 equal 7
// R13 - ten-bit interface init then release
// R14 - force link partner status value
// R15 - both global watermarks set to 256
// R16 - every port: fourth MAC control value
// R17 - every port: both flow thresholds
// R18 - four tail-drop thresholds to 0x3ff
// R19 - every queue: reservation 30 segments
// R20 - every queue: WRED green min/max
// R21 - every queue: strict priority weight
// R22 - finally enable switch core
// R23 - full list only with no-wait and no EEPROM
// R24 - EEPROM self-start request runs same list
// R25 - accesses strictly sequential, in order
// R26 - poll timeout flags failure
// R27 - loops cover every port and queue
module sbl_loader
	import sbl_pkg::*;
#(
	parameter logic [19:0] POLL_LIMIT = POLL_LIMIT_DEF
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [1:0] operating_mode_strap,
	input wire logic [4:0] submode_strap,
	input wire logic [1:0] spi_edge_strap,
	input wire logic no_wait_strap,
	input wire logic eeprom_present,
	input wire logic eeprom_selfstart_req,
	output logic cfg_req,
	output logic cfg_we,
	output logic [15:0] cfg_addr,
	output logic [15:0] cfg_wdata,
	input wire logic cfg_ack,
	input wire logic [15:0] cfg_rdata,
	output logic busy,
	output logic done,
	output logic poll_fail
);
	typedef enum logic [2:0] {S_CAPTURE, S_IDLE, S_LOOK, S_WAIT, S_DONE} sbl_state_type;
	typedef struct packed {
		sbl_state_type st;
		logic [1:0] opm;
		logic [4:0] sub;
		logic [1:0] edges;
		logic nowait;
		logic eep;
		logic full;
		logic [5:0] step;
		logic [5:0] idx;
		logic [19:0] tmo;
		logic start;
		sbl_acc_type op;
		logic [15:0] addr;
		logic [15:0] wdata;
		logic [15:0] mask;
		logic busy;
		logic done;
		logic fail;
	} sbl_top_state_type;
	sbl_top_state_type s_ff, nxt_s;

	logic rst_q_n;
	sbl_kind_type ent_kind;
	logic ent_en;
	logic [15:0] ent_addr;
	logic [15:0] ent_data;
	logic [15:0] ent_mask;
	logic [4:0] mgmt_addr;
	logic [15:0] loop_off;
	logic poll_ok;
	logic last_iter;

	sbl_acc_if acc ();

	sbl_rst_sync u_rst (
		.clk(clk),
		.rst_n(rst_n),
		.rst_q_n(rst_q_n)
	);

	sbl_access u_acc (
		.clk(clk),
		.rst_q_n(rst_q_n),
		.acc(acc),
		.cfg_req(cfg_req),
		.cfg_we(cfg_we),
		.cfg_addr(cfg_addr),
		.cfg_wdata(cfg_wdata),
		.cfg_ack(cfg_ack),
		.cfg_rdata(cfg_rdata)
	);

	always_comb begin
		case (s_ff.sub[1:0])
			2'h0: mgmt_addr = MGMT_ADDR_0; // R2
			2'h1: mgmt_addr = MGMT_ADDR_1;
			2'h2: mgmt_addr = MGMT_ADDR_2;
			default: mgmt_addr = MGMT_ADDR_3;
		endcase
	end

	// the list itself, one entry per step
	always_comb begin
		ent_kind = K_WR;
		ent_en = 1'b1;
		ent_addr = ADDR_CORE_CFG;
		ent_data = CORE_ENABLE;
		ent_mask = FULL_MASK;
		case (s_ff.step)
			6'h00: begin
				ent_kind = K_FLD; // R2
				ent_en = (s_ff.opm == 2'h3);
				ent_addr = ADDR_SLAVE_MGMT;
				ent_data = {7'h00, mgmt_addr, 4'h0};
				ent_mask = MGMT_ADDR_MASK;
			end
			6'h01: begin
				ent_kind = K_FLD; // R3 R4
				ent_en = (s_ff.opm == 2'h2);
				ent_addr = ADDR_SLAVE_SPI;
				ent_data = {~s_ff.edges[0], ~s_ff.edges[1], 13'h0000, 1'b1};
				ent_mask = SPI_CFG_MASK;
			end
			6'h02: begin
				ent_kind = K_FLD; // R4
				ent_en = (s_ff.opm == 2'h2);
				ent_addr = ADDR_ALTSEL_FIRST;
				ent_data = ALTSEL_FIRST_VAL;
				ent_mask = ALTSEL_MASK;
			end
			6'h03: begin
				ent_kind = K_FLD; // R4
				ent_en = (s_ff.opm == 2'h2);
				ent_addr = ADDR_ALTSEL_SECOND;
				ent_data = ALTSEL_SECOND_VAL;
				ent_mask = ALTSEL_MASK;
			end
			6'h04: begin
				ent_kind = K_FLD; // R5
				ent_addr = ADDR_P5_IF_CFG;
				ent_data = P5_IF_RGMII;
				ent_mask = P5_IF_MASK;
			end
			6'h05: begin
				ent_addr = ADDR_P5_LINK; // R5
				ent_data = P5_LINK_VAL;
			end
			6'h06: begin
				ent_kind = K_FLD; // R6
				ent_en = s_ff.sub[4];
				ent_addr = ADDR_P5_CLK_DLY;
				ent_data = RX_DLY_2NS;
				ent_mask = RX_DLY_MASK;
			end
			6'h07: begin
				ent_kind = K_FLD; // R7
				ent_en = s_ff.sub[3];
				ent_addr = ADDR_P5_CLK_DLY;
				ent_data = TX_DLY_2NS;
				ent_mask = TX_DLY_MASK;
			end
			6'h08: begin
				ent_addr = ADDR_P4_LINK; // R8
				ent_data = P4_LINK_VAL;
			end
			6'h09: begin
				ent_kind = K_FLD; // R9
				ent_en = s_ff.sub[2];
				ent_addr = ADDR_OSC_CTRL;
				ent_data = OSC_2G5;
				ent_mask = OSC_MASK;
			end
			6'h0a: begin
				ent_addr = ADDR_RST_REQ; // R10
				ent_data = RST_REQ_VAL;
			end
			6'h0b: begin
				ent_addr = ADDR_HW_BRINGUP; // R11
				ent_data = HW_BRINGUP_VAL;
			end
			6'h0c: begin
				ent_kind = K_POLL; // R12
				ent_addr = ADDR_PHY_STATUS;
				ent_data = STATUS_READY;
				ent_mask = STATUS_MASK;
			end
			6'h0d: begin
				ent_addr = ADDR_TBI_CTRL; // R13
				ent_data = TBI_INIT;
			end
			6'h0e: begin
				ent_addr = ADDR_TBI_CTRL; // R13
				ent_data = TBI_RUN;
			end
			6'h0f: begin
				ent_addr = ADDR_TX_BUF_CTRL;
				ent_data = BUF_INIT;
			end
			6'h10: begin
				ent_addr = ADDR_TX_BUF_CTRL;
				ent_data = BUF_RUN;
			end
			6'h11: begin
				ent_addr = ADDR_RX_BUF_CTRL;
				ent_data = BUF_INIT;
			end
			6'h12: begin
				ent_addr = ADDR_RX_BUF_CTRL;
				ent_data = BUF_RUN;
			end
			6'h13: begin
				ent_addr = ADDR_ANEG_CTRL;
				ent_data = ANEG_VAL;
			end
			6'h14: begin
				ent_addr = ADDR_LP_STATUS; // R14
				ent_data = LP_STATUS_VAL;
			end
			6'h15: begin
				ent_addr = ADDR_GWM_FIRST; // R15
				ent_data = GWM_VAL;
			end
			6'h16: begin
				ent_addr = ADDR_GWM_SECOND; // R15
				ent_data = GWM_VAL;
			end
			6'h17: begin
				ent_kind = K_PORT; // R16
				ent_addr = ADDR_MAC_CTRL4;
				ent_data = MAC_CTRL4_VAL;
			end
			6'h18: begin
				ent_kind = K_PORT; // R17
				ent_addr = ADDR_FLOW_FIRST;
				ent_data = FLOW_FIRST_VAL;
			end
			6'h19: begin
				ent_kind = K_PORT; // R17
				ent_addr = ADDR_FLOW_SECOND;
				ent_data = FLOW_SECOND_VAL;
			end
			6'h1a, 6'h1b, 6'h1c, 6'h1d: begin
				ent_addr = ADDR_TAIL_DROP + {14'h0000, 2'(s_ff.step - 6'h1a)}; // R18
				ent_data = TAIL_DROP_VAL;
			end
			6'h1e: begin
				ent_kind = K_QUEUE; // R19
				ent_addr = ADDR_Q_RESV;
				ent_data = Q_RESV_VAL;
			end
			6'h1f: begin
				ent_kind = K_QUEUE; // R20
				ent_addr = ADDR_Q_WRED_MIN;
				ent_data = Q_WRED_VAL;
			end
			6'h20: begin
				ent_kind = K_QUEUE; // R20
				ent_addr = ADDR_Q_WRED_MAX;
				ent_data = Q_WRED_VAL;
			end
			6'h21: begin
				ent_kind = K_QUEUE; // R21
				ent_addr = ADDR_Q_WEIGHT;
				ent_data = Q_WEIGHT_VAL;
			end
			STEP_CORE: begin
				ent_addr = ADDR_CORE_CFG; // R22
				ent_data = CORE_ENABLE;
			end
			default: begin
				ent_kind = K_END;
			end
		endcase
	end

	assign loop_off = (ent_kind == K_PORT) ? 16'(s_ff.idx) * PORT_STRIDE :
		(ent_kind == K_QUEUE) ? 16'(s_ff.idx) * QUEUE_STRIDE : 16'h0000;
	assign last_iter = (ent_kind == K_PORT) ? (s_ff.idx == LAST_PORT) : // R27
		(ent_kind == K_QUEUE) ? (s_ff.idx == LAST_QUEUE) : 1'b1;
	assign poll_ok = ((acc.rdata & STATUS_MASK) == STATUS_READY); // R12

	always_comb begin
		nxt_s = s_ff;
		nxt_s.start = 1'b0;
		case (s_ff.st)
			S_CAPTURE: begin
				// straps are caught once, after reset release
				nxt_s.opm = operating_mode_strap;
				nxt_s.sub = submode_strap;
				nxt_s.edges = spi_edge_strap;
				nxt_s.nowait = no_wait_strap;
				nxt_s.eep = eeprom_present;
				nxt_s.st = S_IDLE;
			end
			S_IDLE: begin
				if (!s_ff.opm[1]) begin
					nxt_s.st = S_DONE; // R1
				end else if (eeprom_selfstart_req) begin
					nxt_s.full = 1'b1; // R24
					nxt_s.busy = 1'b1;
					nxt_s.st = S_LOOK;
				end else if (!s_ff.nowait || !s_ff.eep) begin
					nxt_s.full = s_ff.nowait; // R23
					nxt_s.busy = 1'b1;
					nxt_s.st = S_LOOK;
				end
			end
			S_LOOK: begin
				nxt_s.idx = (ent_kind == K_POLL) ? s_ff.idx : s_ff.idx;
				if (ent_kind == K_END || (!s_ff.full && s_ff.step > STEP_SLAVE_LAST)) begin
					nxt_s.st = S_DONE; // R23
				end else if (!ent_en) begin
					nxt_s.step = s_ff.step + 6'h01;
				end else begin
					nxt_s.start = 1'b1; // R25
					nxt_s.op = (ent_kind == K_POLL) ? ACC_RD :
						(ent_kind == K_FLD) ? ACC_RMW : ACC_WR;
					nxt_s.addr = ent_addr + loop_off;
					nxt_s.wdata = ent_data;
					nxt_s.mask = ent_mask;
					nxt_s.st = S_WAIT;
				end
			end
			S_WAIT: begin
				if (acc.done) begin
					nxt_s.st = S_LOOK;
					if (ent_kind == K_POLL && !poll_ok) begin
						nxt_s.tmo = s_ff.tmo + 20'h00001;
						if (s_ff.tmo >= POLL_LIMIT) begin
							nxt_s.fail = 1'b1; // R26
							nxt_s.st = S_DONE;
						end
					end else if (!last_iter) begin
						nxt_s.idx = s_ff.idx + 6'h01; // R27
					end else begin
						nxt_s.idx = 6'h00;
						nxt_s.step = s_ff.step + 6'h01; // R25
					end
				end
			end
			S_DONE: begin
				nxt_s.busy = 1'b0;
				nxt_s.done = 1'b1;
				// a late self-start request with the mode strap upper bit set runs the full list, unless the poll has timed out
				if (eeprom_selfstart_req && s_ff.opm[1] && !s_ff.fail) begin
					nxt_s.done = 1'b0;
					nxt_s.busy = 1'b1;
					nxt_s.full = 1'b1; // R24
					nxt_s.step = 6'h00;
					nxt_s.tmo = 20'h00000;
					nxt_s.st = S_LOOK;
				end
			end
			default: begin
				nxt_s.st = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_q_n) begin
		if (!rst_q_n) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign acc.start = s_ff.start;
	assign acc.op = s_ff.op;
	assign acc.addr = s_ff.addr;
	assign acc.wdata = s_ff.wdata;
	assign acc.mask = s_ff.mask;
	assign busy = s_ff.busy;
	assign done = s_ff.done;
	assign poll_fail = s_ff.fail;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_q_n);

	sequence s_core_written;
		s_ff.st == S_WAIT && acc.done && s_ff.step == STEP_CORE;
	endsequence
	property p_core_last;
		s_core_written |=> s_ff.st == S_LOOK ##1 s_ff.st == S_DONE ##1 done;
	endproperty
	a_core_last: assert property (p_core_last) else $error("core enable not last"); // R22
	property p_poll_hold;
		s_ff.st == S_WAIT && acc.done && ent_kind == K_POLL && !poll_ok && s_ff.tmo < POLL_LIMIT
			|=> s_ff.st == S_LOOK && $stable(s_ff.step) ##1 acc.start && acc.op == ACC_RD;
	endproperty
	a_poll_hold: assert property (p_poll_hold) else $error("poll advanced early"); // R12
	property p_slave_only;
		s_ff.st == S_LOOK && !s_ff.full && s_ff.step > STEP_SLAVE_LAST |=> s_ff.st == S_DONE;
	endproperty
	a_slave_only: assert property (p_slave_only) else $error("list ran past slave setup"); // R23
	property p_mgmt_addr;
		acc.start && s_ff.step == 6'h00 && s_ff.sub[1:0] == 2'h3 |-> acc.wdata[8:4] == 5'h1f;
	endproperty
	a_mgmt_addr: assert property (p_mgmt_addr) else $error("management address wrong"); // R2
	property p_spi_cfg;
		acc.start && s_ff.step == 6'h01 |-> acc.wdata[15] == !s_ff.edges[0]
			&& acc.wdata[14] == !s_ff.edges[1] && acc.wdata[0] && acc.op == ACC_RMW;
	endproperty
	a_spi_cfg: assert property (p_spi_cfg) else $error("slave SPI config wrong"); // R3
	property p_loop_stays;
		s_ff.st == S_WAIT && acc.done && ent_kind == K_PORT && s_ff.idx < LAST_PORT
			|=> $stable(s_ff.step) && s_ff.idx == $past(s_ff.idx) + 6'h01;
	endproperty
	a_loop_stays: assert property (p_loop_stays) else $error("port loop cut short"); // R27
	property p_one_access;
		acc.start |=> !acc.start [*2];
	endproperty
	a_one_access: assert property (p_one_access) else $error("accesses overlap"); // R25
endmodule : sbl_loader

/* File: core/sbl_pkg.sv */
// constants and types for the self-start boot configuration loader
// assumes the switch core register space is reached with 16-bit addresses and data
package sbl_pkg;
	// switch core geometry
	localparam int unsigned NUM_PORTS = 6;
	localparam int unsigned NUM_QUEUES = 32;
	localparam logic [5:0] LAST_PORT = 6'(NUM_PORTS - 1);
	localparam logic [5:0] LAST_QUEUE = 6'(NUM_QUEUES - 1);
	// register addresses inside the switch core
	localparam logic [15:0] ADDR_SLAVE_MGMT = 16'h0010;
	localparam logic [15:0] ADDR_SLAVE_SPI = 16'h0011;
	localparam logic [15:0] ADDR_ALTSEL_FIRST = 16'h0020;
	localparam logic [15:0] ADDR_ALTSEL_SECOND = 16'h0021;
	localparam logic [15:0] ADDR_P5_IF_CFG = 16'h0030;
	localparam logic [15:0] ADDR_P5_LINK = 16'h0031;
	localparam logic [15:0] ADDR_P5_CLK_DLY = 16'h0032;
	localparam logic [15:0] ADDR_P4_LINK = 16'h0033;
	localparam logic [15:0] ADDR_OSC_CTRL = 16'h0040;
	localparam logic [15:0] ADDR_RST_REQ = 16'h0041;
	localparam logic [15:0] ADDR_HW_BRINGUP = 16'h0042;
	localparam logic [15:0] ADDR_PHY_STATUS = 16'h0043;
	localparam logic [15:0] ADDR_TBI_CTRL = 16'h0044;
	localparam logic [15:0] ADDR_TX_BUF_CTRL = 16'h0045;
	localparam logic [15:0] ADDR_RX_BUF_CTRL = 16'h0046;
	localparam logic [15:0] ADDR_ANEG_CTRL = 16'h0047;
	localparam logic [15:0] ADDR_LP_STATUS = 16'h0048;
	localparam logic [15:0] ADDR_GWM_FIRST = 16'h0050;
	localparam logic [15:0] ADDR_GWM_SECOND = 16'h0051;
	localparam logic [15:0] ADDR_TAIL_DROP = 16'h0054;
	localparam logic [15:0] ADDR_MAC_CTRL4 = 16'h0100;
	localparam logic [15:0] ADDR_FLOW_FIRST = 16'h0101;
	localparam logic [15:0] ADDR_FLOW_SECOND = 16'h0102;
	localparam logic [15:0] PORT_STRIDE = 16'h0010;
	localparam logic [15:0] ADDR_Q_RESV = 16'h0200;
	localparam logic [15:0] ADDR_Q_WRED_MIN = 16'h0201;
	localparam logic [15:0] ADDR_Q_WRED_MAX = 16'h0202;
	localparam logic [15:0] ADDR_Q_WEIGHT = 16'h0203;
	localparam logic [15:0] QUEUE_STRIDE = 16'h0004;
	localparam logic [15:0] ADDR_CORE_CFG = 16'h0300;
	// field masks and values
	localparam logic [15:0] MGMT_ADDR_MASK = 16'h01f0;
	localparam logic [4:0] MGMT_ADDR_0 = 5'h00;
	localparam logic [4:0] MGMT_ADDR_1 = 5'h04;
	localparam logic [4:0] MGMT_ADDR_2 = 5'h10;
	localparam logic [4:0] MGMT_ADDR_3 = 5'h1f;
	localparam logic [15:0] SPI_CFG_MASK = 16'hc001;
	localparam logic [15:0] ALTSEL_MASK = 16'h003c;
	localparam logic [15:0] ALTSEL_FIRST_VAL = 16'h003c;
	localparam logic [15:0] ALTSEL_SECOND_VAL = 16'h0000;
	localparam logic [15:0] P5_IF_MASK = 16'h6000;
	localparam logic [15:0] P5_IF_RGMII = 16'h4000;
	localparam logic [15:0] P5_LINK_VAL = 16'h32a5;
	localparam logic [15:0] RX_DLY_MASK = 16'h0380;
	localparam logic [15:0] RX_DLY_2NS = 16'h0200;
	localparam logic [15:0] TX_DLY_MASK = 16'h0007;
	localparam logic [15:0] TX_DLY_2NS = 16'h0004;
	localparam logic [15:0] P4_LINK_VAL = 16'h32a4;
	localparam logic [15:0] OSC_MASK = 16'h000e;
	localparam logic [15:0] OSC_2G5 = 16'h000e;
	localparam logic [15:0] RST_REQ_VAL = 16'h000f;
	localparam logic [15:0] HW_BRINGUP_VAL = 16'h0009;
	localparam logic [15:0] STATUS_MASK = 16'h0f80;
	localparam logic [15:0] STATUS_READY = 16'h0380;
	localparam logic [15:0] TBI_INIT = 16'h0033;
	localparam logic [15:0] TBI_RUN = 16'h0032;
	localparam logic [15:0] BUF_INIT = 16'h0003;
	localparam logic [15:0] BUF_RUN = 16'h0001;
	localparam logic [15:0] ANEG_VAL = 16'h00f0;
	localparam logic [15:0] LP_STATUS_VAL = 16'h0021;
	localparam logic [15:0] GWM_VAL = 16'h0100;
	localparam logic [15:0] MAC_CTRL4_VAL = 16'h1494;
	localparam logic [15:0] FLOW_FIRST_VAL = 16'h0018;
	localparam logic [15:0] FLOW_SECOND_VAL = 16'h001e;
	localparam logic [15:0] TAIL_DROP_VAL = 16'h03ff;
	localparam logic [15:0] Q_RESV_VAL = 16'h001e;
	localparam logic [15:0] Q_WRED_VAL = 16'h03ff;
	localparam logic [15:0] Q_WEIGHT_VAL = 16'hffff;
	localparam logic [15:0] CORE_ENABLE = 16'h8000;
	localparam logic [15:0] FULL_MASK = 16'hffff;
	// list positions and default poll limit
	localparam logic [5:0] STEP_SLAVE_LAST = 6'h03;
	localparam logic [5:0] STEP_CORE = 6'h22;
	localparam logic [19:0] POLL_LIMIT_DEF = 20'h186a0;

	typedef enum logic [1:0] {ACC_WR, ACC_RMW, ACC_RD} sbl_acc_type;
	typedef enum logic [2:0] {K_WR, K_FLD, K_POLL, K_PORT, K_QUEUE, K_END} sbl_kind_type;
endpackage : sbl_pkg

/* File: core/sbl_rst_sync.sv */
// reset release synchroniser
// assumes rst_n may fall at any time; release is taken on clk
module sbl_rst_sync (
	input wire logic clk,
	input wire logic rst_n,
	output logic rst_q_n
);
	logic [1:0] sync_ff;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_ff <= 2'h0;
		end else begin
			sync_ff <= {sync_ff[0], 1'b1};
		end
	end
	assign rst_q_n = sync_ff[1];
endmodule : sbl_rst_sync

/* File: sim/sbl_core_model.sv */
// model of the switch core register space seen by the boot loader
// assumes one access at a time; ack comes dly+1 cycles after a request is seen
module sbl_core_model
	import sbl_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [1:0] dly,
	input wire logic [7:0] ready_after,
	input wire logic cfg_req,
	input wire logic cfg_we,
	input wire logic [15:0] cfg_addr,
	input wire logic [15:0] cfg_wdata,
	output logic cfg_ack,
	output logic [15:0] cfg_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [0:1023];
	logic [1:0] wait_ff;
	logic [7:0] polls;
	logic [15:0] last_addr;
	int n_wr;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// untouched registers keep a mixed pattern so field merges show
			foreach (mem[i]) mem[i] <= 16'h5a5a;
			cfg_ack <= 1'b0;
			cfg_rdata <= 16'h0000;
			wait_ff <= 2'h0;
			polls <= 8'h00;
			last_addr <= 16'h0000;
			n_wr <= 0;
		end else if (cfg_ack) begin
			cfg_ack <= 1'b0;
			// read data is only valid in the ack cycle
			cfg_rdata <= ~cfg_rdata;
			wait_ff <= 2'h0;
			if (cfg_we) begin
				mem[cfg_addr[9:0]] <= cfg_wdata;
				last_addr <= cfg_addr;
				n_wr <= n_wr + 1;
			end
		end else if (cfg_req && wait_ff == dly) begin
			cfg_ack <= 1'b1;
			cfg_rdata <= mem[cfg_addr[9:0]];
			if (cfg_addr == ADDR_PHY_STATUS) begin
				polls <= polls + 8'h01;
				cfg_rdata <= (polls >= ready_after) ? 16'hf3ff : 16'h0c7f;
			end
		end else if (cfg_req) begin
			wait_ff <= wait_ff + 2'h1;
		end
	end
endmodule : sbl_core_model

/* File: sim/tb.sv */
// self-checking bench for the self-start boot loader
// assumes straps are set while reset is held and stay put until the next reset
module tb
	import sbl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_n = 0, nw = 0, eep = 0, ereq = 0, req, we, ack, busy, done, pf;
	logic [1:0] om = 0, se = 0, dly = 0;
	logic [4:0] sm = 0;
	logic [7:0] rdy = 0;
	logic [15:0] addr, wd, rd;
	int failures = 0, n_tests = 0, cyc = 0;
	always #2 clk = ~clk;
	sbl_loader #(.POLL_LIMIT(20'h00008)) uut (.clk(clk), .rst_n(rst_n),
		.operating_mode_strap(om), .submode_strap(sm), .spi_edge_strap(se),
		.no_wait_strap(nw), .eeprom_present(eep), .eeprom_selfstart_req(ereq),
		.cfg_req(req), .cfg_we(we), .cfg_addr(addr), .cfg_wdata(wd), .cfg_ack(ack),
		.cfg_rdata(rd), .busy(busy), .done(done), .poll_fail(pf));
	sbl_core_model core (.clk(clk), .rst_n(rst_n), .dly(dly), .ready_after(rdy),
		.cfg_req(req), .cfg_we(we), .cfg_addr(addr), .cfg_wdata(wd), .cfg_ack(ack),
		.cfg_rdata(rd));
	task results;
		$display("failures %0d n_tests %0d", failures, n_tests);
		if (failures == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : results
	task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	function logic [15:0] m(input logic [15:0] a);
		return core.mem[a[9:0]];
	endfunction : m
	function logic [15:0] f(input logic [15:0] mask, input logic [15:0] v);
		return (16'h5a5a & ~mask) | (v & mask);
	endfunction : f
	task run(input logic [1:0] o, input logic [4:0] s, input logic [1:0] e, input logic w,
		input logic p);
		@(negedge clk);
		rst_n = 0;
		om = o;
		sm = s;
		se = e;
		nw = w;
		eep = p;
		repeat (10) @(negedge clk);
		rst_n = 1;
	endtask : run
	task wait_done;
		for (int i = 0; i < 20000 && done !== 1'b1; i++) @(negedge clk);
		if (done !== 1'b1) begin
			failures++;
			results();
		end
	endtask : wait_done
	task t_full;
		dly = 2;
		rdy = 3;
		run(2'b11, 5'h1f, 2'b00, 1, 0);
		wait_done();
		chk("mgmt", f(16'h01f0, 16'h01f0), m(ADDR_SLAVE_MGMT));
		chk("p5 if", f(16'h6000, 16'h4000), m(ADDR_P5_IF_CFG));
		chk("p5 link", 16'h32a5, m(ADDR_P5_LINK));
		chk("p5 delay", f(16'h0387, 16'h0204), m(ADDR_P5_CLK_DLY));
		chk("p4 link", 16'h32a4, m(ADDR_P4_LINK));
		chk("osc", f(16'h000e, 16'h000e), m(ADDR_OSC_CTRL));
		chk("rst", 16'h000f, m(ADDR_RST_REQ));
		chk("bringup", 16'h0009, m(ADDR_HW_BRINGUP));
		chk("polls", 16'h0004, {8'h00, core.polls});
		chk("tbi", 16'h0032, m(ADDR_TBI_CTRL));
		chk("lp", 16'h0021, m(ADDR_LP_STATUS));
		chk("gwm", 16'h0100, m(ADDR_GWM_FIRST) & m(ADDR_GWM_SECOND));
		for (int p = 0; p < 6; p++) begin
			chk("mac4", 16'h1494, m(ADDR_MAC_CTRL4 + 16'(p * 16)));
			chk("flow1", 16'h0018, m(ADDR_FLOW_FIRST + 16'(p * 16)));
			chk("flow2", 16'h001e, m(ADDR_FLOW_SECOND + 16'(p * 16)));
		end
		for (int t = 0; t < 4; t++) chk("tail", 16'h03ff, m(ADDR_TAIL_DROP + 16'(t)));
		for (int q = 0; q < 32; q++) begin
			chk("resv", 16'h001e, m(ADDR_Q_RESV + 16'(q * 4)));
			chk("wred min", 16'h03ff, m(ADDR_Q_WRED_MIN + 16'(q * 4)));
			chk("wred max", 16'h03ff, m(ADDR_Q_WRED_MAX + 16'(q * 4)));
			chk("weight", 16'hffff, m(ADDR_Q_WEIGHT + 16'(q * 4)));
		end
		chk("core", 16'h8000, m(ADDR_CORE_CFG));
		chk("last", 16'h0300, core.last_addr);
		chk("flags", 16'h0002, {13'h0, busy, done, pf});
	endtask : t_full
	task t_slave;
		logic [4:0] ma [4] = '{5'h00, 5'h04, 5'h10, 5'h1f};
		dly = 0;
		for (int k = 0; k < 4; k++) begin
			run(2'b10, 5'h00, 2'(k), 0, 0);
			wait_done();
			chk("spi", f(16'hc001, {~se[0], ~se[1], 13'h0, 1'b1}), m(ADDR_SLAVE_SPI));
			chk("alt1", f(16'h003c, 16'h003c), m(ADDR_ALTSEL_FIRST));
			chk("alt2", f(16'h003c, 16'h0000), m(ADDR_ALTSEL_SECOND));
			chk("core", 16'h5a5a, m(ADDR_CORE_CFG) & m(ADDR_P5_LINK));
			run(2'b11, 5'(k), 2'b00, 0, 0);
			wait_done();
			chk("mgmt", f(16'h01f0, {7'h0, ma[k], 4'h0}), m(ADDR_SLAVE_MGMT));
			chk("spi", 16'h5a5a, m(ADDR_SLAVE_SPI) & m(ADDR_CORE_CFG));
		end
	endtask : t_slave
	task t_eep;
		int n;
		run(2'b01, 5'h1f, 2'b00, 1, 0);
		wait_done();
		chk("writes", 16'h0000, 16'(core.n_wr));
		run(2'b10, 5'h00, 2'b11, 1, 1);
		repeat (50) @(negedge clk);
		chk("writes", 16'h0000, 16'(core.n_wr));
		ereq = 1;
		@(negedge clk);
		ereq = 0;
		wait_done();
		chk("core", 16'h8000, m(ADDR_CORE_CFG));
		chk("p5 delay", 16'h5a5a, m(ADDR_P5_CLK_DLY));
		chk("osc", 16'h5a5a, m(ADDR_OSC_CTRL));
		// a request after the list has finished runs it once more
		n = core.n_wr;
		ereq = 1;
		@(negedge clk);
		ereq = 0;
		wait_done();
		chk("rerun", 16'(2 * n), 16'(core.n_wr));
	endtask : t_eep
	task t_fail;
		rdy = 8'hff;
		run(2'b11, 5'h00, 2'b00, 1, 0);
		wait_done();
		chk("flags", 16'h0003, {13'h0, busy, done, pf});
		chk("after poll", 16'h5a5a, m(ADDR_TBI_CTRL) & m(ADDR_CORE_CFG));
		// after a poll failure a self-start request must be ignored
		ereq = 1;
		@(negedge clk);
		ereq = 0;
		repeat (20) @(negedge clk);
		chk("refused", 16'h0003, {13'h0, busy, done, pf});
	endtask : t_fail
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			failures++;
			results();
		end
	end
	initial begin
		t_full();
		t_slave();
		t_eep();
		t_fail();
		results();
	end
endmodule : tb
